// ==== inc/adc_ctrl_pkg.sv ====
// shared constants, register map and state types of the converter control block
package adc_ctrl_pkg;
	localparam int NCONV = 2;
	localparam int RES_N = 8;
	localparam int QDEPTH = 4;
	localparam int DW = 16;
	localparam int AW = 7;
	localparam int RW = 12;
	localparam int SARW = 10;
	localparam int NSH = 10;
	// address layout: bit 6 selects the shared bank, bit 4 the converter
	localparam int ADR_SHARED = 6;
	localparam int ADR_CONV = 4;
	localparam int ADR_RES = 3;
	// per-converter registers
	localparam logic [3:0] A_PAR_MASK = 4'h0;
	localparam logic [3:0] A_PAR_START = 4'h1;
	localparam logic [3:0] A_QUEUE = 4'h2;
	localparam logic [3:0] A_INSERT = 4'h3;
	localparam logic [3:0] A_PEND = 4'h4;
	// shared registers
	localparam logic [3:0] A_CTRL = 4'h0;
	localparam logic [3:0] A_TIMING = 4'h1;
	localparam logic [3:0] A_PRIO = 4'h2;
	localparam logic [3:0] A_LIM_LO = 4'h3;
	localparam logic [3:0] A_LIM_HI = 4'h4;
	localparam logic [3:0] A_RES_CFG = 4'h5;
	localparam logic [3:0] A_BWIRE = 4'h6;
	localparam logic [3:0] A_TRIG = 4'h7;
	localparam logic [3:0] A_STATUS = 4'h8;
	localparam logic [3:0] A_MASK = 4'h9;
	// control fields
	localparam int C_EN = 0;
	localparam int C_SYNC = 1;
	localparam int C_M8 = 2;
	localparam int C_MTEST = 3;
	localparam int C_EXT = 4;
	localparam int C_EXTA = 6;
	localparam int C_ETC = 7;
	// timing fields
	localparam int T_SAMP = 0;
	localparam int T_STEP = 8;
	// priority and target fields
	localparam int P_INS = 0;
	localparam int P_PAR = 2;
	localparam int P_QUE = 4;
	localparam int G_INS = 6;
	localparam int G_PAR = 9;
	localparam int G_QUE = 12;
	// result configuration fields
	localparam int R_WFR = 0;
	localparam int R_FIFO = 8;
	localparam int R_FLAST = 9;
	localparam int R_ACC = 12;
	localparam int R_LMODE = 14;
	// trigger fields
	localparam int TG_SEL = 0;
	localparam int TG_EN = 4;
	// status bits
	localparam int S_RES = 0;
	localparam int S_LIM = 2;
	localparam logic [15:0] RST_TIMING = 16'h0303;
	localparam logic [9:0] SAR_MSB = 10'h200;
	localparam logic [3:0] BIT_TOP = 4'h9;
	localparam logic [3:0] BIT_LOW10 = 4'h0;
	localparam logic [3:0] BIT_LOW8 = 4'h2;
	localparam logic [1:0] LM_OFF = 2'h0;
	localparam logic [1:0] LM_OUTSIDE = 2'h1;
	localparam logic [1:0] LM_INSIDE = 2'h2;

	typedef enum logic [1:0] {PH_IDLE, PH_SAMPLE, PH_CONV} phase_e;
	typedef enum logic [1:0] {SRC_INS, SRC_PAR, SRC_QUE} src_e;

	typedef struct packed {
		phase_e phase;
		logic [7:0] cnt;
		logic [3:0] bitn;
		logic [SARW-1:0] sar;
		logic m8;
		logic [3:0] chan;
		logic [2:0] tgt;
		logic [15:0] pmask;
		logic [15:0] pend;
		logic [QDEPTH-1:0][3:0] q;
		logic [2:0] qn;
		logic ins_v;
		logic [3:0] ins_ch;
		logic [RES_N-1:0][RW-1:0] res;
		logic [RES_N-1:0] vld;
		logic [2:0] wp;
		logic [2:0] rp;
		logic [RW-1:0] acc;
		logic [1:0] accn;
		logic [1:0] ext;
		logic etc;
	} conv_s;

	typedef struct packed {
		logic [NCONV-1:0] conv_dummy_pad;
		logic [NSH-1:0][DW-1:0] sh;
		logic [3:0] trig_q;
		logic [DW-1:0] rdata;
		conv_s [NCONV-1:0] cv;
	} state_s;

	// analog front-end controls of one converter
	typedef struct packed {
		logic [3:0] chan;
		logic sample;
		logic [SARW-1:0] dac;
		logic power;
		logic bw_pre;
		logic [1:0] ext_mux;
	} ana_s;
endpackage

// ==== hdl/adc_request_result_control.sv ====
// request sequencing, SAR control and result handling for two converters
//
// The implementer's own choices: the register offsets and strobed register access.
`timescale 1ns/1ps

module adc_request_result_control
	import adc_ctrl_pkg::*;
(
	input wire logic clk,
	input wire logic reset,
	input wire logic [AW-1:0] addr,
	input wire logic [DW-1:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [DW-1:0] rdata,
	input wire logic [3:0] trig_in,
	input wire logic [NCONV-1:0] cmp_hi,
	output ana_s [NCONV-1:0] ana,
	output logic [NCONV-1:0] etc_req,
	output logic mux_test,
	output logic irq
);
	state_s st_r;
	state_s st_nxt;
	logic [15:0] ctl, tim, pri, rcf, trg;
	logic [NCONV-1:0] has, stall, go, start;
	logic [NCONV-1:0][3:0] a_ch;
	logic [NCONV-1:0][2:0] a_tg;
	src_e [NCONV-1:0] a_src;

	function automatic logic [3:0] first_set(input logic [15:0] p);
		logic [3:0] f;
		f = 4'h0;
		for (int i = 15; i >= 0; i--)
			if (p[i])
				f = 4'(i);
		return f;
	endfunction

	function automatic logic [2:0] wrap(input logic [2:0] p, input logic [2:0] last);
		return (p == last) ? 3'h0 : p + 3'h1;
	endfunction

	// chained registers are addressed through the FIFO pointer instead
	function automatic logic [2:0] tmap(input logic [2:0] tg, input logic [15:0] cfg,
		input logic [2:0] ptr);
		return (cfg[R_FIFO] && tg <= cfg[R_FLAST +: 3]) ? ptr : tg;
	endfunction

	assign ctl = st_r.sh[A_CTRL];
	assign tim = st_r.sh[A_TIMING];
	assign pri = st_r.sh[A_PRIO];
	assign rcf = st_r.sh[A_RES_CFG];
	assign trg = st_r.sh[A_TRIG];

	// arbitration: ties go to insertion, then parallel, then queue
	always_comb
	begin
		has = '0;
		stall = '0;
		go = '0;
		a_ch = '0;
		a_tg = '0;
		for (int c = 0; c < NCONV; c++)
		begin
			logic [1:0] bp;
			logic [2:0] t;
			bp = 2'h0;
			t = 3'h0;
			a_src[c] = SRC_QUE;
			if (st_r.cv[c].qn != 3'h0)
			begin
				has[c] = 1'b1;
				a_src[c] = SRC_QUE;
				bp = pri[P_QUE +: 2];
				a_ch[c] = st_r.cv[c].q[0];
				a_tg[c] = pri[G_QUE +: 3];
			end
			if (st_r.cv[c].pend != 16'h0000 && (!has[c] || pri[P_PAR +: 2] >= bp))
			begin
				has[c] = 1'b1;
				a_src[c] = SRC_PAR;
				bp = pri[P_PAR +: 2];
				a_ch[c] = first_set(st_r.cv[c].pend);
				a_tg[c] = pri[G_PAR +: 3];
			end
			if (st_r.cv[c].ins_v && (!has[c] || pri[P_INS +: 2] >= bp))
			begin
				has[c] = 1'b1;
				a_src[c] = SRC_INS;
				a_ch[c] = st_r.cv[c].ins_ch;
				a_tg[c] = pri[G_INS +: 3];
			end
			t = tmap(a_tg[c], rcf, st_r.cv[c].wp);
			stall[c] = rcf[R_WFR + int'(t)] && st_r.cv[c].vld[t];
			go[c] = ctl[C_EN] && has[c] && !stall[c] && st_r.cv[c].phase == PH_IDLE;
		end
		// converter_one follows converter_zero so both sample together
		start[0] = go[0] && (!ctl[C_SYNC] || st_r.cv[1].phase == PH_IDLE);
		start[1] = ctl[C_SYNC] ? (start[0] && go[1]) : go[1];
	end

	always_comb
	begin
		logic [3:0] rise;
		logic [2:0] idx;
		logic [RW-1:0] val;
		logic outl, keep;
		rise = trig_in & ~st_r.trig_q;
		idx = 3'h0;
		val = '0;
		outl = 1'b0;
		keep = 1'b0;
		st_nxt = st_r;
		st_nxt.rdata = '0;
		st_nxt.trig_q = trig_in;
		if (rd && addr[ADR_SHARED])
			st_nxt.rdata = (addr[3:0] <= A_MASK) ? st_r.sh[addr[3:0]] : 16'h0000;
		if (wr && addr[ADR_SHARED] && addr[3:0] <= A_MASK)
			st_nxt.sh[addr[3:0]] = (addr[3:0] == A_STATUS) ? (st_r.sh[A_STATUS] & ~wdata)
				: wdata;
		for (int c = 0; c < NCONV; c++)
		begin
			logic sel;
			sel = !addr[ADR_SHARED] && addr[ADR_CONV] == 1'(c);
			st_nxt.cv[c].etc = 1'b0;
			// reads clear valid before a store in the same cycle can set it
			if (rd && sel && addr[ADR_RES])
			begin
				idx = tmap(addr[2:0], rcf, st_r.cv[c].rp);
				st_nxt.rdata = {st_r.cv[c].vld[idx], 3'h0, st_r.cv[c].res[idx]};
				st_nxt.cv[c].vld[idx] = 1'b0;
				if (idx == st_r.cv[c].rp && rcf[R_FIFO] && addr[2:0] <= rcf[R_FLAST +: 3])
					st_nxt.cv[c].rp = wrap(st_r.cv[c].rp, rcf[R_FLAST +: 3]);
			end
			else if (rd && sel && addr[3:0] == A_PEND)
				st_nxt.rdata = st_r.cv[c].pend;
			unique case (st_r.cv[c].phase)
				PH_IDLE:
				begin
					if (start[c])
					begin
						st_nxt.cv[c].phase = PH_SAMPLE;
						st_nxt.cv[c].cnt = tim[T_SAMP +: 8];
						st_nxt.cv[c].chan = (c == 1) ? {1'b0, a_ch[c][2:0]} : a_ch[c];
						st_nxt.cv[c].tgt = a_tg[c];
						st_nxt.cv[c].m8 = ctl[C_M8];
						st_nxt.cv[c].sar = SAR_MSB;
						st_nxt.cv[c].bitn = BIT_TOP;
						if (!ctl[C_EXTA])
							st_nxt.cv[c].ext = ctl[C_EXT +: 2];
						unique case (a_src[c])
							SRC_INS: st_nxt.cv[c].ins_v = 1'b0;
							SRC_PAR: st_nxt.cv[c].pend[a_ch[c]] = 1'b0;
							SRC_QUE:
							begin
								for (int i = 0; i < QDEPTH - 1; i++)
									st_nxt.cv[c].q[i] = st_r.cv[c].q[i + 1];
								st_nxt.cv[c].qn = st_r.cv[c].qn - 3'h1;
							end
						endcase
					end
				end
				PH_SAMPLE:
				begin
					if (st_r.cv[c].cnt == 8'h00)
					begin
						st_nxt.cv[c].phase = PH_CONV;
						st_nxt.cv[c].cnt = tim[T_STEP +: 8];
					end
					else
						st_nxt.cv[c].cnt = st_r.cv[c].cnt - 8'h01;
				end
				PH_CONV:
				begin
					if (st_r.cv[c].cnt != 8'h00)
						st_nxt.cv[c].cnt = st_r.cv[c].cnt - 8'h01;
					else
					begin
						if (!cmp_hi[c])
							st_nxt.cv[c].sar[st_r.cv[c].bitn] = 1'b0;
						if (st_r.cv[c].bitn == (st_r.cv[c].m8 ? BIT_LOW8 : BIT_LOW10))
						begin
							st_nxt.cv[c].phase = PH_IDLE;
							if (ctl[C_EXTA])
								st_nxt.cv[c].ext = st_r.cv[c].ext + 2'h1;
							val = st_r.cv[c].acc + RW'(st_nxt.cv[c].sar);
							if (st_r.cv[c].accn != rcf[R_ACC +: 2])
							begin
								st_nxt.cv[c].acc = val;
								st_nxt.cv[c].accn = st_r.cv[c].accn + 2'h1;
							end
							else
							begin
								st_nxt.cv[c].acc = '0;
								st_nxt.cv[c].accn = 2'h0;
								outl = val < st_r.sh[A_LIM_LO][RW-1:0]
									|| val > st_r.sh[A_LIM_HI][RW-1:0];
								unique case (rcf[R_LMODE +: 2])
									LM_OFF: keep = 1'b1;
									LM_OUTSIDE: keep = outl;
									LM_INSIDE: keep = !outl;
									default: keep = 1'b1;
								endcase
								if (rcf[R_LMODE +: 2] != LM_OFF && outl)
									st_nxt.sh[A_STATUS][S_LIM + c] = 1'b1;
								if (keep)
								begin
									idx = tmap(st_r.cv[c].tgt, rcf, st_r.cv[c].wp);
									st_nxt.cv[c].res[idx] = val;
									st_nxt.cv[c].vld[idx] = 1'b1;
									if (idx == st_r.cv[c].wp && rcf[R_FIFO]
										&& st_r.cv[c].tgt <= rcf[R_FLAST +: 3])
										st_nxt.cv[c].wp = wrap(st_r.cv[c].wp,
											rcf[R_FLAST +: 3]);
									st_nxt.sh[A_STATUS][S_RES + c] = 1'b1;
									st_nxt.cv[c].etc = ctl[C_ETC + c];
								end
							end
						end
						else
						begin
							st_nxt.cv[c].bitn = st_r.cv[c].bitn - 4'h1;
							st_nxt.cv[c].sar[st_r.cv[c].bitn - 4'h1] = 1'b1;
							st_nxt.cv[c].cnt = tim[T_STEP +: 8];
						end
					end
				end
				default: st_nxt.cv[c].phase = PH_IDLE;
			endcase
			// writes and triggers after consumption, so a start in the same cycle never loses a new request; a queue write is dropped if four remain after consumption
			if (wr && sel)
			begin
				unique case (addr[3:0])
					A_PAR_MASK: st_nxt.cv[c].pmask = wdata;
					A_PAR_START: st_nxt.cv[c].pend = st_nxt.cv[c].pend | st_r.cv[c].pmask;
					A_QUEUE:
						if (st_nxt.cv[c].qn < 3'(QDEPTH))
						begin
							st_nxt.cv[c].q[st_nxt.cv[c].qn[1:0]] = wdata[3:0];
							st_nxt.cv[c].qn = st_nxt.cv[c].qn + 3'h1;
						end
					A_INSERT:
					begin
						st_nxt.cv[c].ins_v = 1'b1;
						st_nxt.cv[c].ins_ch = wdata[3:0];
					end
					default: st_nxt.cv[c].ins_v = st_nxt.cv[c].ins_v;
				endcase
			end
			if (trg[TG_EN + c] && rise[trg[TG_SEL + 2 * c +: 2]])
				st_nxt.cv[c].pend = st_nxt.cv[c].pend | st_r.cv[c].pmask;
		end
		if (reset)
		begin
			st_nxt = '0;
			st_nxt.sh[A_TIMING] = RST_TIMING;
		end
	end

	always_ff @(posedge clk)
	begin
		st_r <= st_nxt;
	end

	always_comb
	begin
		for (int c = 0; c < NCONV; c++)
		begin
			ana[c].chan = st_r.cv[c].chan;
			ana[c].sample = st_r.cv[c].phase == PH_SAMPLE;
			ana[c].dac = st_r.cv[c].sar;
			ana[c].power = st_r.cv[c].phase != PH_IDLE;
			ana[c].bw_pre = ana[c].sample && st_r.sh[A_BWIRE][st_r.cv[c].chan]
				&& st_r.cv[c].cnt == tim[T_SAMP +: 8];
			ana[c].ext_mux = st_r.cv[c].ext;
			etc_req[c] = st_r.cv[c].etc;
		end
	end

	assign rdata = st_r.rdata;
	assign mux_test = ctl[C_MTEST];
	assign irq = |(st_r.sh[A_STATUS] & st_r.sh[A_MASK]);

	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	property p_samp_end;
		st_r.cv[0].phase == PH_SAMPLE && st_r.cv[0].cnt == 8'h00 |=> st_r.cv[0].phase == PH_CONV;
	endproperty
	a_samp_end: assert property (p_samp_end) else $error("sample phase end wrong");

	property p_sync;
		ctl[C_SYNC] && $rose(ana[1].sample) |-> $rose(ana[0].sample);
	endproperty
	a_sync: assert property (p_sync) else $error("synchronised start lost");

	property p_pwr;
		$fell(ana[0].power) |-> $past(st_r.cv[0].phase) == PH_CONV && !ana[0].sample;
	endproperty
	a_pwr: assert property (p_pwr) else $error("power dropped outside conversion end");

	property p_wfr;
		rcf[R_WFR + 4] && st_r.cv[0].vld[4] |=> st_r.cv[0].res[4] == $past(st_r.cv[0].res[4]);
	endproperty
	a_wfr: assert property (p_wfr) else $error("blocked register overwritten");

	property p_par_order;
		start[0] && a_src[0] == SRC_PAR |=>
			(($past(st_r.cv[0].pend) >> st_r.cv[0].chan) & 16'h0001) == 16'h0001
			&& ($past(st_r.cv[0].pend) << (5'h10 - 5'(st_r.cv[0].chan))) == 16'h0000;
	endproperty
	a_par_order: assert property (p_par_order) else $error("parallel order broken");

	property p_etc;
		etc_req[0] |-> st_r.sh[A_STATUS][S_RES] && $past(st_r.cv[0].phase) == PH_CONV;
	endproperty
	a_etc: assert property (p_etc) else $error("transfer request without result");

	property p_bw;
		ana[1].bw_pre |-> ana[1].sample ##1 !ana[1].bw_pre;
	endproperty
	a_bw: assert property (p_bw) else $error("precharge outside first sample cycle");

	property p_mode8;
		st_r.cv[0].phase == PH_CONV && st_r.cv[0].m8 |-> st_r.cv[0].sar[1:0] == 2'h0;
	endproperty
	a_mode8: assert property (p_mode8) else $error("8-bit mode touched low bits");
endmodule

// ==== dv/analog_source.sv ====
// analog channel model answering the comparator of each converter
`timescale 1ns/1ps
module analog_source
	import adc_ctrl_pkg::*;
(
	input wire logic clk,
	input wire ana_s [NCONV-1:0] ana,
	output logic [NCONV-1:0] cmp_hi
);
	logic toggle_r;
	always @(posedge clk)
	begin
		toggle_r <= ~toggle_r;
	end
	initial toggle_r = 1'b0;
	// level of a channel is its number in the top bits; unpowered input gives noise
	always_comb
	begin
		for (int c = 0; c < NCONV; c++)
		begin
			if (ana[c].power)
				cmp_hi[c] = ({ana[c].chan, 6'h15} >= ana[c].dac);
			else
				cmp_hi[c] = toggle_r ^ c[0];
		end
	end
endmodule

// ==== dv/adc_request_result_control_bench.sv ====
// self-checking bench for the converter request and result control
`timescale 1ns/1ps
module adc_request_result_control_bench;
	import adc_ctrl_pkg::*;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic [AW-1:0] addr = '0;
	logic [DW-1:0] wdata = '0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [3:0] trig_in = 4'h0;
	logic [DW-1:0] rdata;
	logic [NCONV-1:0] cmp_hi;
	ana_s [NCONV-1:0] ana;
	logic [NCONV-1:0] etc_req;
	logic mux_test;
	logic irq;
	int err_total = 0;
	int comparisons = 0;
	int cycles = 0;

	always #12.5 clk = ~clk;

	adc_request_result_control u_dut (
		.clk(clk), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata(rdata), .trig_in(trig_in), .cmp_hi(cmp_hi), .ana(ana),
		.etc_req(etc_req), .mux_test(mux_test), .irq(irq)
	);
	analog_source u_src (.clk(clk), .ana(ana), .cmp_hi(cmp_hi));

	function automatic logic [DW-1:0] res_word(input logic [3:0] ch, input logic m8);
		logic [9:0] v;
		v = {ch, 6'h15};
		if (m8)
			v[1:0] = 2'h0;
		return {4'h8, 2'h0, v};
	endfunction

	task automatic chk(input logic [DW-1:0] got, input logic [DW-1:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			err_total++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wr_reg(input logic [AW-1:0] a, input logic [DW-1:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	// read data stand only in the cycle after the strobe
	task automatic rd_chk(input logic [AW-1:0] a, input logic [DW-1:0] exp);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		chk(rdata, exp);
	endtask

	// counts result pulses of converter_zero; returns cycles to the first
	task automatic wait_done(input int n, output int first);
		int seen;
		int k;
		seen = 0;
		first = -1;
		for (k = 1; k < 600 && seen < n; k++)
		begin
			@(posedge clk);
			#1;
			if (etc_req[0] === 1'b1)
			begin
				seen++;
				if (first < 0)
					first = k;
			end
		end
		chk(16'(seen), 16'(n));
	endtask

	task automatic t_reset_values();
		rd_chk(7'h41, RST_TIMING);
		rd_chk(7'h40, 16'h0000);
		rd_chk(7'h4A, 16'h0000);
		rd_chk(7'h05, 16'h0000);
		$display("test reset_values done");
	endtask

	// single insertion; timing: sample S+1, steps P+1 each
	task automatic t_single(input logic m8, input logic [3:0] ch);
		int n;
		wr_reg(7'h40, m8 ? 16'h0085 : 16'h0081);
		wr_reg(7'h03, {12'h0, ch});
		wait_done(1, n);
		chk(16'(n), m8 ? 16'd20 : 16'd24);
		chk({15'h0, ana[0].power}, 16'h0000);
		rd_chk(7'h0B, res_word(ch, m8));
		rd_chk(7'h0B, res_word(ch, m8) & 16'h7FFF);
		$display("test single done");
	endtask

	task automatic t_irq();
		chk({15'h0, irq}, 16'h0000);
		wr_reg(7'h49, 16'h0001);
		#1;
		chk({15'h0, irq}, 16'h0001);
		wr_reg(7'h48, 16'h0001);
		#1;
		chk({15'h0, irq}, 16'h0000);
		$display("test irq done");
	endtask

	// trigger event starts the parallel source into a three-entry fifo
	task automatic t_parallel_fifo();
		int n;
		wr_reg(7'h45, 16'h0500);
		wr_reg(7'h47, 16'h0011);
		wr_reg(7'h00, 16'h0224);
		@(posedge clk);
		trig_in <= 4'h2;
		@(posedge clk);
		trig_in <= 4'h0;
		wait_done(3, n);
		rd_chk(7'h08, res_word(4'h2, 1'b0));
		rd_chk(7'h08, res_word(4'h5, 1'b0));
		rd_chk(7'h08, res_word(4'h9, 1'b0));
		wr_reg(7'h45, 16'h0000);
		$display("test parallel_fifo done");
	endtask

	// queue into one register guarded by wait-for-read
	task automatic t_queue_wfr();
		int n;
		wr_reg(7'h45, 16'h0010);
		wr_reg(7'h02, 16'h0007);
		wr_reg(7'h02, 16'h0003);
		wr_reg(7'h02, 16'h000B);
		wait_done(1, n);
		repeat (80) @(posedge clk);
		chk({15'h0, ana[0].power}, 16'h0000);
		rd_chk(7'h0C, res_word(4'h7, 1'b0));
		wait_done(1, n);
		rd_chk(7'h0C, res_word(4'h3, 1'b0));
		wait_done(1, n);
		rd_chk(7'h0C, res_word(4'hB, 1'b0));
		wr_reg(7'h45, 16'h0000);
		$display("test queue_wfr done");
	endtask

	// store only inside the window: a result outside is dropped
	task automatic t_limit();
		int n;
		wr_reg(7'h43, 16'h0100);
		wr_reg(7'h44, 16'h0200);
		wr_reg(7'h45, 16'h8000);
		wr_reg(7'h03, 16'h0005);
		wait_done(1, n);
		rd_chk(7'h0B, res_word(4'h5, 1'b0));
		wr_reg(7'h03, 16'h0009);
		repeat (60) @(posedge clk);
		rd_chk(7'h0B, res_word(4'h5, 1'b0) & 16'h7FFF);
		rd_chk(7'h48, 16'h0005);
		wr_reg(7'h45, 16'h0000);
		$display("test limit done");
	endtask

	// both converters start together; converter_one keeps three channel bits
	task automatic t_sync();
		int n;
		wr_reg(7'h40, 16'h019B);
		#1;
		chk({15'h0, mux_test}, 16'h0001);
		wr_reg(7'h46, 16'h0020);
		wr_reg(7'h13, 16'h000D);
		wr_reg(7'h03, 16'h0006);
		@(posedge clk);
		#1;
		chk({14'h0, ana[1].sample, ana[0].sample}, 16'h0003);
		chk({14'h0, ana[1].bw_pre, ana[0].bw_pre}, 16'h0002);
		chk({12'h0, ana[1].chan}, 16'h0005);
		chk({14'h0, ana[0].ext_mux}, 16'h0001);
		wait_done(1, n);
		chk({14'h0, etc_req}, 16'h0003);
		rd_chk(7'h1B, res_word(4'h5, 1'b0));
		rd_chk(7'h0B, res_word(4'h6, 1'b0));
		$display("test sync done");
	endtask

	// two results of channel 5 summed into one store; mux select steps per conversion
	task automatic t_accum_ext();
		int n;
		wr_reg(7'h40, 16'h00C1);
		wr_reg(7'h45, 16'h1000);
		wr_reg(7'h03, 16'h0005);
		wr_reg(7'h03, 16'h0005);
		wait_done(1, n);
		rd_chk(7'h0B, 16'h82AA);
		chk({14'h0, ana[0].ext_mux}, 16'h0003);
		wr_reg(7'h45, 16'h0000);
		$display("test accum_ext done");
	endtask

	task automatic results();
		$display("comparisons %0d mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	always @(posedge clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 20000)
		begin
			err_total++;
			results();
		end
	end

	initial
	begin
		repeat (2) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		t_reset_values();
		wr_reg(7'h41, 16'h0102);
		wr_reg(7'h42, 16'h40C0);
		t_single(1'b0, 4'h9);
		t_irq();
		t_single(1'b1, 4'h9);
		wr_reg(7'h40, 16'h0081);
		t_parallel_fifo();
		t_queue_wfr();
		t_limit();
		t_sync();
		t_accum_ext();
		results();
	end
endmodule
